// File: include/pbm_pkg.sv
// Constants, types and field layouts for the port B upper pin override mux.
// Assumes a single 10 MHz system clock and an AHB-Lite register slave.
//
// Operation
// - Crystal clock sources take port B bit 1 as oscillator pin, no I/O.
// - RC oscillator or external clock leaves port B bit 1 as plain I/O.
// - Port B bit 1 feeds pin change source 9 of group 1.
// - Port B bit 2 can be the external interrupt zero input.
// - Timer 0 compare A reaches bit 2 only with its direction bit set.
// - Compare A on bit 2 also carries timer 0 PWM output.
// - Clock output fuse drives system clock on bit 2, ignoring data and direction.
// - Clock output on bit 2 continues while the device is in reset.
// - Port B bit 2 feeds pin change source 10 of group 1.
// - Bit 3 is active low reset input when the disable fuse reads one.
// - As reset input, bit 3 has pull-up on, driver and digital input off.
// - Single-wire debug active only with its fuse programmed and lock bits clear.
// - Debug mode runs the reset pin open-drain, wired-AND, with pull-up.
// - Port B bit 3 feeds pin change source 11 of group 1.
// - Bit 2 value override picks system clock if clock out, else compare A.
// - Bit 2 input enable forced one for interrupt zero or enabled source 10.
// - Each pin has override pairs, tristate override, digital tap and analog path.
// - Reset disable signal is one when its fuse reads zero.

package pbm_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] PBM_OFS_DATA = 8'h00;
	localparam logic [7:0] PBM_OFS_DIR = 8'h04;
	localparam logic [7:0] PBM_OFS_PIN = 8'h08;
	localparam logic [7:0] PBM_OFS_MASK = 8'h0C;
	localparam logic [7:0] PBM_OFS_CTRL = 8'h10;
	localparam logic [7:0] PBM_OFS_STAT = 8'h14;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [3:1] PBM_DATA_RST = 3'h0;
	localparam logic [3:1] PBM_DIR_RST = 3'h0;
	localparam logic [3:1] PBM_MASK_RST = 3'h0;
	localparam logic [2:0] PBM_CTRL_RST = 3'h0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PBM_CTRL_GRP1_EN = 0;
	localparam int PBM_CTRL_EXT_IRQ_ZERO_EN = 1;
	localparam int PBM_CTRL_PUD = 2;
	localparam int PBM_STAT_EXT_OSC = 0;
	localparam int PBM_STAT_CLK_OUT = 1;
	localparam int PBM_STAT_RST_PIN = 2;
	localparam int PBM_STAT_DBG_ACT = 3;
	localparam int PBM_STAT_RST_DIS = 4;
	localparam int PBM_PIN_OSC = 1;
	localparam int PBM_PIN_CLK = 2;
	localparam int PBM_PIN_RST = 3;

	// Fuse cells read zero when programmed
	localparam logic PBM_FUSE_PROG = 1'b0;
	localparam logic PBM_HRESP_OKAY = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PBM_CLK_RC,
		PBM_CLK_EXT,
		PBM_CLK_XTAL,
		PBM_CLK_LF_XTAL
	} pbm_clk_src_e;

	typedef struct packed {
		pbm_clk_src_e clk_src;
		logic sys_clock_out_fuse;
		logic reset_pin_disable_fuse;
		logic single_wire_debug_fuse;
		logic lock_bits_unprog;
	} pbm_fuse_s;

	typedef struct packed {
		logic compare_a_en;
		logic compare_a_out;
	} pbm_timer_s;

	typedef struct packed {
		logic puoe;
		logic puov;
		logic ddoe;
		logic ddov;
		logic pvoe;
		logic pvov;
		logic ptoe;
		logic dieoe;
		logic dieov;
	} pbm_ovr_s;

endpackage : pbm_pkg

// File: design/pbm_pin_cell.sv
// One port pin with its alternate-function override controls applied.
// Assumes pin inputs already synchronous to the system clock.
`timescale 1ns/10ps

module pbm_pin_cell
(
	input wire logic pad_in,
	input wire logic port_data,
	input wire logic port_dir,
	input wire logic pull_up_disable,
	input wire pbm_pkg::pbm_ovr_s ovr,
	output logic pad_out,
	output logic pad_oe,
	output logic pullup_en,
	output logic din,
	output logic aio
);

	logic dir_eff;
	logic val_eff;
	logic die_eff;

	// Overrides win over the port registers
	always_comb
	begin
		dir_eff = ovr.ddoe ? ovr.ddov : port_dir;
		val_eff = ovr.pvoe ? ovr.pvov : port_data;
		die_eff = ovr.dieoe ? ovr.dieov : 1'b1;
	end

	// Pad drive; tristate override releases the driver
	assign pad_oe = dir_eff & ~ovr.ptoe;
	assign pad_out = val_eff;

	// Pull-up only on an input with data one, unless overridden
	assign pullup_en = ovr.puoe ? ovr.puov : (~dir_eff & port_data & ~pull_up_disable);

	// Gated digital tap and raw analog path
	assign din = die_eff & pad_in;
	assign aio = pad_in;

endmodule : pbm_pin_cell

// File: design/pbm_port_b_mux.sv
// Alternate-function override mux for port B bits 1 to 3, with its
// data, direction, pin, mask, control and status registers on AHB-Lite.
// Assumes one slave on the bus, fuses stable, pad inputs synchronous.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps

module pbm_port_b_mux
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire pbm_pkg::pbm_fuse_s fuses,
	input wire pbm_pkg::pbm_timer_s timer0,
	input wire logic single_wire_debug_tx,
	input wire logic [3:1] port_b_pin_in,
	output logic [3:1] port_b_pin_out,
	output logic [3:1] port_b_pin_oe,
	output logic [3:1] port_b_pullup_en,
	output logic osc_out_pin,
	output logic ext_reset_n,
	output logic single_wire_debug_active,
	output logic single_wire_debug_line,
	output logic ext_irq_zero,
	output logic pin_change_event
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [3:1] port_data_reg;
	logic [3:1] port_dir_reg;
	logic [3:1] pc_mask_reg;
	logic [2:0] ctrl_reg;
	logic [3:1] din_prev_reg;
	logic pin_change_event_reg;
	logic ext_irq_zero_reg;
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [7:0] acc_addr_reg;
	logic acc_mapped_reg;

	logic addr_phase;
	logic addr_mapped;
	logic ext_osc;
	logic clk_out_en;
	logic reset_disable;
	logic reset_pin_mode;
	logic grp1_en;
	logic ext_irq_zero_en;
	logic pud;
	logic pc_src_9_en;
	logic pc_src_10_en;
	logic pc_src_11_en;
	logic [3:1] din;
	logic [3:1] aio;
	logic [3:1] pc_change;
	logic [4:0] status;
	logic [31:0] rd_mux;
	pbm_pkg::pbm_ovr_s ovr [3:1];

	// ------------------------------------------------------------
	// Fuse and control decode
	// ------------------------------------------------------------

	// Crystal sources claim the oscillator pin; RC and external clock do not
	assign ext_osc = (fuses.clk_src == pbm_pkg::PBM_CLK_XTAL)
		| (fuses.clk_src == pbm_pkg::PBM_CLK_LF_XTAL);

	// Clock output fuse is active low like every fuse cell
	assign clk_out_en = (fuses.sys_clock_out_fuse == pbm_pkg::PBM_FUSE_PROG);

	// Reset disable is one when its fuse reads zero
	assign reset_disable = (fuses.reset_pin_disable_fuse == pbm_pkg::PBM_FUSE_PROG);

	// Debug needs fuse programmed and lock bits left open
	assign single_wire_debug_active =
		(fuses.single_wire_debug_fuse == pbm_pkg::PBM_FUSE_PROG)
		& fuses.lock_bits_unprog;

	// Reset pin role: fuse unprogrammed and debug not taking the pin
	assign reset_pin_mode = ~reset_disable & ~single_wire_debug_active;

	// Software enables
	assign grp1_en = ctrl_reg[pbm_pkg::PBM_CTRL_GRP1_EN];
	assign ext_irq_zero_en = ctrl_reg[pbm_pkg::PBM_CTRL_EXT_IRQ_ZERO_EN];
	assign pud = ctrl_reg[pbm_pkg::PBM_CTRL_PUD];

	// Pin change sources qualified by the group enable
	assign pc_src_9_en = pc_mask_reg[pbm_pkg::PBM_PIN_OSC] & grp1_en;
	assign pc_src_10_en = pc_mask_reg[pbm_pkg::PBM_PIN_CLK] & grp1_en;
	assign pc_src_11_en = pc_mask_reg[pbm_pkg::PBM_PIN_RST] & grp1_en;

	// ------------------------------------------------------------
	// Override signals, port B bit 1 (oscillator pin)
	// ------------------------------------------------------------

	// Oscillator owns the pad: pull-up, driver and value all forced off
	always_comb
	begin
		ovr[1].puoe = ext_osc;
		ovr[1].puov = 1'b0;
		ovr[1].ddoe = ext_osc;
		ovr[1].ddov = 1'b0;
		ovr[1].pvoe = ext_osc;
		ovr[1].pvov = 1'b0;
		ovr[1].ptoe = 1'b0;
		// Input stays on for pin change only when the pin is free
		ovr[1].dieoe = ext_osc | pc_src_9_en;
		ovr[1].dieov = ~ext_osc & pc_src_9_en;
	end

	// ------------------------------------------------------------
	// Override signals, port B bit 2 (clock out, compare A, irq zero)
	// ------------------------------------------------------------

	// Clock output takes the pad fully; compare A only borrows the value,
	// so the direction bit must still be set for it to reach the pad.
	always_comb
	begin
		ovr[2].puoe = clk_out_en;
		ovr[2].puov = 1'b0;
		ovr[2].ddoe = clk_out_en;
		ovr[2].ddov = 1'b1;
		ovr[2].pvoe = clk_out_en | timer0.compare_a_en;
		// Raw clock passes here; no flop, so it runs through reset too
		ovr[2].pvov = clk_out_en ? clk : timer0.compare_a_out;
		ovr[2].ptoe = 1'b0;
		ovr[2].dieoe = pc_src_10_en | ext_irq_zero_en;
		ovr[2].dieov = pc_src_10_en | ext_irq_zero_en;
	end

	// ------------------------------------------------------------
	// Override signals, port B bit 3 (reset, debug line)
	// ------------------------------------------------------------

	// Value override holds zero, so the direction override alone decides
	// whether the line is pulled low: a wired-AND that never drives high.
	always_comb
	begin
		ovr[3].puoe = reset_disable | single_wire_debug_active | reset_pin_mode;
		ovr[3].puov = 1'b1;
		ovr[3].ddoe = reset_disable | single_wire_debug_active | reset_pin_mode;
		ovr[3].ddov = single_wire_debug_active & single_wire_debug_tx;
		ovr[3].pvoe = reset_disable | single_wire_debug_active | reset_pin_mode;
		ovr[3].pvov = 1'b0;
		ovr[3].ptoe = 1'b0;
		ovr[3].dieoe = reset_disable | single_wire_debug_active
			| pc_src_11_en | reset_pin_mode;
		ovr[3].dieov = single_wire_debug_active
			| (reset_disable & pc_src_11_en);
	end

	// ------------------------------------------------------------
	// Pin cells
	// ------------------------------------------------------------

	// Same pad structure on every pin; only the overrides differ
	genvar gi;
	generate
		for (gi = 1; gi <= 3; gi = gi + 1)
		begin : g_pin
			pbm_pin_cell u_cell
			(
				.pad_in(port_b_pin_in[gi]),
				.port_data(port_data_reg[gi]),
				.port_dir(port_dir_reg[gi]),
				.pull_up_disable(pud),
				.ovr(ovr[gi]),
				.pad_out(port_b_pin_out[gi]),
				.pad_oe(port_b_pin_oe[gi]),
				.pullup_en(port_b_pullup_en[gi]),
				.din(din[gi]),
				.aio(aio[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Alternate inputs toward the core
	// ------------------------------------------------------------

	// Oscillator sense taken from the analog path, not the gated tap
	assign osc_out_pin = ext_osc & aio[pbm_pkg::PBM_PIN_OSC];

	// Reset must act without a clock, so it bypasses every flop;
	// the digital tap is off in this mode, hence the analog path.
	assign ext_reset_n = reset_pin_mode ? aio[pbm_pkg::PBM_PIN_RST] : 1'b1;

	// Debug receive idles high like the pulled-up line
	assign single_wire_debug_line = single_wire_debug_active
		? din[pbm_pkg::PBM_PIN_RST] : 1'b1;

	// Interrupt zero level, registered toward the interrupt logic
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ext_irq_zero_reg <= 1'b0;
		else
			ext_irq_zero_reg <= ext_irq_zero_en & din[pbm_pkg::PBM_PIN_CLK];
	end
	assign ext_irq_zero = ext_irq_zero_reg;

	// ------------------------------------------------------------
	// Pin change detection for group 1
	// ------------------------------------------------------------

	// Sources 9, 10 and 11 compared against last cycle's tap
	assign pc_change[1] = pc_src_9_en & (din[1] ^ din_prev_reg[1]);
	assign pc_change[2] = pc_src_10_en & (din[2] ^ din_prev_reg[2]);
	assign pc_change[3] = pc_src_11_en & (din[3] ^ din_prev_reg[3]);

	// Previous tap values
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			din_prev_reg <= 3'h0;
		else
			din_prev_reg <= din;
	end

	// One-cycle event; the flag itself lives in the interrupt block
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pin_change_event_reg <= 1'b0;
		else
			pin_change_event_reg <= |pc_change;
	end
	assign pin_change_event = pin_change_event_reg;

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------

	// Zero wait state, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = pbm_pkg::PBM_HRESP_OKAY;

	// Address phase accepted when selected, ready and non-idle
	assign addr_phase = hsel & hready & htrans[1];
	assign addr_mapped = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);

	// Address and direction held into the data phase
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			acc_addr_reg <= 8'h00;
			acc_mapped_reg <= 1'b0;
		end
		else if (hready)
		begin
			wr_pend_reg <= addr_phase & hwrite;
			rd_pend_reg <= addr_phase & ~hwrite;
			acc_addr_reg <= haddr[7:0];
			acc_mapped_reg <= addr_mapped;
		end
	end

	// Status bits: current decoded pin roles
	assign status = {reset_disable, single_wire_debug_active, reset_pin_mode,
		clk_out_en, ext_osc};

	// Read mux driven from the held data-phase address, so a write in
	// the previous data phase is already visible. Unmapped reads zero.
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (acc_mapped_reg)
		begin
			case (acc_addr_reg)
				pbm_pkg::PBM_OFS_DATA: rd_mux[3:1] = port_data_reg;
				pbm_pkg::PBM_OFS_DIR: rd_mux[3:1] = port_dir_reg;
				pbm_pkg::PBM_OFS_PIN: rd_mux[3:1] = din;
				pbm_pkg::PBM_OFS_MASK: rd_mux[3:1] = pc_mask_reg;
				pbm_pkg::PBM_OFS_CTRL: rd_mux[2:0] = ctrl_reg;
				pbm_pkg::PBM_OFS_STAT: rd_mux[4:0] = status;
				default: rd_mux = 32'h00000000;
			endcase
		end
	end
	assign hrdata = rd_pend_reg ? rd_mux : 32'h00000000;

	// ------------------------------------------------------------
	// Registers written by software
	// ------------------------------------------------------------

	// Port data bits; ignored on bit 2 while clock out owns the pin
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			port_data_reg <= pbm_pkg::PBM_DATA_RST;
		else if (wr_pend_reg && acc_mapped_reg && acc_addr_reg == pbm_pkg::PBM_OFS_DATA)
			port_data_reg <= hwdata[3:1];
	end

	// Direction bits; bit 2 set lets compare A reach the pad
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			port_dir_reg <= pbm_pkg::PBM_DIR_RST;
		else if (wr_pend_reg && acc_mapped_reg && acc_addr_reg == pbm_pkg::PBM_OFS_DIR)
			port_dir_reg <= hwdata[3:1];
	end

	// Pin change source mask, bits 1 to 3 for sources 9 to 11
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pc_mask_reg <= pbm_pkg::PBM_MASK_RST;
		else if (wr_pend_reg && acc_mapped_reg && acc_addr_reg == pbm_pkg::PBM_OFS_MASK)
			pc_mask_reg <= hwdata[3:1];
	end

	// Group enable, interrupt zero enable, pull-up disable
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ctrl_reg <= pbm_pkg::PBM_CTRL_RST;
		else if (wr_pend_reg && acc_mapped_reg && acc_addr_reg == pbm_pkg::PBM_OFS_CTRL)
			ctrl_reg <= hwdata[2:0];
	end

endmodule : pbm_port_b_mux

// File: sim/pbm_port_b_mux_props.sv
// Checker for the port B override mux pins.
// Assumes it is bound to pbm_port_b_mux and sees its ports only.
`timescale 1ns/10ps

module pbm_mux_props
(
	input wire logic clk,
	input wire logic reset_n,
	input wire pbm_pkg::pbm_fuse_s fuses,
	input wire pbm_pkg::pbm_timer_s timer0,
	input wire logic single_wire_debug_tx,
	input wire logic [3:1] port_b_pin_in,
	input wire logic [3:1] port_b_pin_out,
	input wire logic [3:1] port_b_pin_oe,
	input wire logic [3:1] port_b_pullup_en,
	input wire logic osc_out_pin,
	input wire logic ext_reset_n,
	input wire logic single_wire_debug_active,
	input wire logic single_wire_debug_line,
	input wire logic ext_irq_zero,
	input wire logic pin_change_event
);
	// --------
	// Mode decode
	// --------
	logic xt;
	logic ck;
	logic dbg;
	logic rpin;

	// Modes as the fuse cells select them
	assign xt = fuses.clk_src inside {pbm_pkg::PBM_CLK_XTAL, pbm_pkg::PBM_CLK_LF_XTAL};
	assign ck = fuses.sys_clock_out_fuse == pbm_pkg::PBM_FUSE_PROG;
	assign dbg = fuses.single_wire_debug_fuse == pbm_pkg::PBM_FUSE_PROG && fuses.lock_bits_unprog;
	assign rpin = fuses.reset_pin_disable_fuse != pbm_pkg::PBM_FUSE_PROG && !dbg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// --------
	// Properties
	// --------
	AST_OSC_PIN:
	assert property (xt |-> !port_b_pin_oe[1] && osc_out_pin == port_b_pin_in[1])
	else $error("oscillator pin not held");
	AST_NO_OSC:
	assert property (!xt |-> !osc_out_pin)
	else $error("oscillator path open");
	// Clock level seen at negedge is high, so the pin must be high; reset does not stop it
	AST_CLK_HIGH:
	assert property (@(negedge clk) disable iff (1'b0) ck |-> port_b_pin_out[2] && port_b_pin_oe[2])
	else $error("clock output missing high");
	AST_CLK_LOW:
	assert property (ck |-> !port_b_pin_out[2] && port_b_pin_oe[2])
	else $error("clock output missing low");
	AST_CMP_A:
	assert property (!ck && timer0.compare_a_en |-> port_b_pin_out[2] == timer0.compare_a_out)
	else $error("compare output not on pin");
	AST_RST_PIN:
	assert property (rpin |-> port_b_pullup_en[3] && !port_b_pin_oe[3]
		&& ext_reset_n == port_b_pin_in[3])
	else $error("reset pin mode wrong");
	AST_NOT_RST:
	assert property (!rpin |-> ext_reset_n)
	else $error("reset seen while pin disabled");
	AST_DBG_ACT:
	assert property (single_wire_debug_active == dbg)
	else $error("debug activation wrong");
	AST_DBG_WIRE:
	assert property (dbg |-> !port_b_pin_out[3] && port_b_pin_oe[3] == single_wire_debug_tx
		&& single_wire_debug_line == port_b_pin_in[3])
	else $error("debug line not open drain");
	AST_BIT3_PULL:
	assert property (port_b_pullup_en[3] && (dbg || !port_b_pin_oe[3]))
	else $error("bit 3 pull-up or driver wrong");
	AST_IRQ0:
	assert property (ext_irq_zero |-> $past(port_b_pin_in[2]))
	else $error("interrupt zero without input");
	AST_PC_EVT:
	assert property (pin_change_event |-> $past(port_b_pin_in) != $past(port_b_pin_in, 2))
	else $error("pin change event without change");

	// Main scenarios reached
	cover property (pin_change_event);
	cover property (dbg && single_wire_debug_tx);
	cover property (@(negedge clk) disable iff (1'b0) !reset_n && ck && port_b_pin_out[2]);
endmodule : pbm_mux_props

bind pbm_port_b_mux pbm_mux_props u_props (.clk(clk), .reset_n(reset_n), .fuses(fuses),
	.timer0(timer0), .single_wire_debug_tx(single_wire_debug_tx), .port_b_pin_in(port_b_pin_in),
	.port_b_pin_out(port_b_pin_out), .port_b_pin_oe(port_b_pin_oe),
	.port_b_pullup_en(port_b_pullup_en), .osc_out_pin(osc_out_pin), .ext_reset_n(ext_reset_n),
	.single_wire_debug_active(single_wire_debug_active),
	.single_wire_debug_line(single_wire_debug_line), .ext_irq_zero(ext_irq_zero),
	.pin_change_event(pin_change_event));

// File: sim/pbm_pad_model.sv
// Pads of port B bits 1 to 3 with crystal, drivers and debug emulator.
// Assumes the bench steers the outside drivers; pads resolve here.
`timescale 1ns/10ps

module pbm_pad_model
(
	input wire logic clk,
	input wire logic [3:1] pin_out,
	input wire logic [3:1] pin_oe,
	input wire logic [3:1] pullup_en,
	input wire logic [3:1] ext_val,
	input wire logic [3:1] ext_drv,
	input wire logic xtal_on,
	input wire logic emu_low,
	output logic [3:1] pin_in
);
	// --------
	// Wire levels
	// --------
	logic [3:1] last_reg = 3'h0;
	logic xtal_reg = 1'b0;

	// Crystal swings on its own; a floating pad shows no stale level
	always @(posedge clk)
	begin
		xtal_reg <= ~xtal_reg;
		last_reg <= pin_in;
	end

	// Resolve each pad; bit 3 is a wired-AND line with the emulator
	always_comb
	begin
		for (int b = 1; b < 4; b++)
		begin
			if (pin_oe[b]) pin_in[b] = pin_out[b];
			else if (ext_drv[b]) pin_in[b] = ext_val[b];
			else if (pullup_en[b]) pin_in[b] = 1'b1;
			else pin_in[b] = ~last_reg[b];
		end
		if (xtal_on) pin_in[1] = xtal_reg;
		if (emu_low || (pin_oe[3] && !pin_out[3])) pin_in[3] = 1'b0;
	end
endmodule : pbm_pad_model

// File: sim/testbench.sv
// Self-checking bench for the port B override mux.
// Assumes the pad model and the bound checker; AHB-Lite master here.
`timescale 1ns/10ps

module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	pbm_pkg::pbm_fuse_s fuses = pbm_pkg::pbm_fuse_s'(6'h0E);
	pbm_pkg::pbm_timer_s timer0 = 2'h0;
	logic tx = 1'b0;
	logic emu_low = 1'b0;
	logic xtal_on = 1'b0;
	logic [3:1] ext_val = 3'h0;
	logic [3:1] ext_drv = 3'h0;
	logic [3:1] pin_in, pin_out, pin_oe, pull_en;
	logic osc, rst_n_out, dbg_act, dbg_line, irq0, pc_evt;
	int failures = 0;
	int tests_run = 0;
	int seed = 20;
	logic [31:0] q;
	logic [31:0] m [7];
	logic [31:0] rw [7] = '{32'hE, 32'hE, 32'h0, 32'hE, 32'h7, 32'h0, 32'h0};
	logic [7:0] ofs [6] = '{pbm_pkg::PBM_OFS_DATA, pbm_pkg::PBM_OFS_DIR, pbm_pkg::PBM_OFS_PIN,
		pbm_pkg::PBM_OFS_MASK, pbm_pkg::PBM_OFS_CTRL, pbm_pkg::PBM_OFS_STAT};
	logic [31:0] pmask [3] = '{32'hE, 32'hE, 32'h0};
	logic [31:0] pctl [3] = '{32'h3, 32'h2, 32'h1};

	pbm_port_b_mux dut
	(
		.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fuses(fuses), .timer0(timer0),
		.single_wire_debug_tx(tx), .port_b_pin_in(pin_in), .port_b_pin_out(pin_out),
		.port_b_pin_oe(pin_oe), .port_b_pullup_en(pull_en), .osc_out_pin(osc),
		.ext_reset_n(rst_n_out), .single_wire_debug_active(dbg_act),
		.single_wire_debug_line(dbg_line), .ext_irq_zero(irq0), .pin_change_event(pc_evt)
	);

	pbm_pad_model pads
	(
		.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pull_en), .ext_val(ext_val),
		.ext_drv(ext_drv), .xtal_on(xtal_on), .emu_low(emu_low), .pin_in(pin_in)
	);

	// --------
	// Helpers
	// --------
	initial
		forever #50 clk = ~clk;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Bounded wait for hready; a hang counts as a mismatch
	task automatic ready_wait;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) failures++;
	endtask : ready_wait

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		ready_wait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		ready_wait();
		r = hrdata;
	endtask : bus

	// Index 6 is an unmapped word
	task automatic put(input int k, input logic [31:0] d);
		bus(1'b1, k < 6 ? ofs[k] : 8'h18, d, q);
		m[k] = d & rw[k];
	endtask : put

	// Status bits follow the fuse cells directly
	function automatic logic [31:0] stat_exp(input logic [5:0] f);
		logic g;
		g = !f[1] && f[0];
		return {27'h0, !f[2], g, f[2] && !g, !f[3], f[5]};
	endfunction : stat_exp

	task automatic sweep;
		for (int k = 0; k < 7; k++)
			if (k != 2)
			begin
				bus(1'b0, k < 6 ? ofs[k] : 8'h18, 32'h0, q);
				check("reg", q, k == 5 ? stat_exp(fuses) : m[k]);
				check("resp", hresp, pbm_pkg::PBM_HRESP_OKAY);
			end
	endtask : sweep

	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	// Watchdog: the run needs under a thousand cycles only
	initial
	begin
		#1_000_000;
		failures++;
		tally_and_finish();
	end

	// --------
	// Tests
	// --------
	initial
	begin
		logic [5:0] f;
		logic [31:0] d;
		logic [3:1] dt, dr;
		logic x, c, g, r, w;
		for (int k = 0; k < 7; k++) m[k] = 32'h0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		sweep();
		// Group and interrupt zero enables kept off: floating pads and the
		// clock on bit 2 would otherwise race the event and interrupt flops
		for (int k = 0; k < 7; k++) put(k, $random(seed) & ~(k == 4 ? 32'h3 : 32'h0));
		sweep();
		$display("test registers done");
		for (int i = 0; i < 64; i++)
		begin
			put(0, $random(seed));
			put(1, $random(seed));
			@(posedge clk);
			f = 6'(i);
			d = $random(seed);
			fuses <= pbm_pkg::pbm_fuse_s'(f);
			timer0 <= pbm_pkg::pbm_timer_s'(d[1:0]);
			tx <= d[2];
			emu_low <= d[3];
			xtal_on <= f[5];
			@(posedge clk);
			#1;
			x = f[5];
			c = !f[3];
			g = !f[1] && f[0];
			r = f[2] && !g;
			w = !(d[3] || (g && d[2]));
			dt = m[0][3:1];
			dr = m[1][3:1];
			check("oe", pin_oe, {g && d[2], c || dr[2], !x && dr[1]});
			check("pull", pull_en, {1'b1, !c && !dr[2] && dt[2] && !m[4][2],
				!x && !dr[1] && dt[1] && !m[4][2]});
			if (!c && dr[2]) check("out2", pin_out[2], d[1] ? d[0] : dt[2]);
			if (!x && dr[1]) check("out1", pin_out[1], dt[1]);
			check("rst", rst_n_out, r ? w : 1'b1);
			check("dbg", {dbg_act, dbg_line}, {g, g ? w : 1'b1});
			check("osc", osc, x && pin_in[1]);
			bus(1'b0, ofs[5], 32'h0, q);
			check("stat", q, stat_exp(f));
		end
		$display("test fuse modes done");
		fuses <= pbm_pkg::pbm_fuse_s'(6'h0A);
		emu_low <= 1'b0;
		xtal_on <= 1'b0;
		ext_drv <= 3'h7;
		put(1, 32'h0);
		for (int p = 0; p < 3; p++)
		begin
			put(3, pmask[p]);
			put(4, pctl[p]);
			for (int b = 1; b < 4; b++)
			begin
				@(posedge clk);
				ext_val[b] <= !ext_val[b];
				@(posedge clk);
				#1;
				check("event", pc_evt, p == 0);
				@(posedge clk);
				#1;
				check("event_end", pc_evt, 1'b0);
				check("irq0", irq0, pctl[p][1] && ext_val[2]);
			end
		end
		$display("test pin change done");
		@(posedge clk);
		fuses <= pbm_pkg::pbm_fuse_s'(6'h00);
		reset_n <= 1'b0;
		@(posedge clk);
		#10;
		check("sys_clock_out_fuse_high", {pin_out[2], pin_oe[2]}, 2'h3);
		@(negedge clk);
		#10;
		check("sys_clock_out_fuse_low", {pin_out[2], pin_oe[2]}, 2'h1);
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		for (int k = 0; k < 7; k++) m[k] = 32'h0;
		sweep();
		$display("test reset done");
		tally_and_finish();
	end
endmodule : testbench
